// ### hdl/qhbs_host_port.sv
// Host bus front end shared by four serial channels
`timescale 1ns/100ps
`include "qhbs_map.svh"
module qhbs_host_port import qhbs_pkg::*; (
   input wire logic clk, // System clock, 200 MHz
   input wire logic rst, // System reset, active high
   input wire logic bus_style_sel, // High strobe style, low read/write-line
   input wire logic irq_style_select, // Interrupt style pin
   input wire logic chip_reset_pin, // Chip reset pin, polarity by bus style
   input wire logic chan0_select_n, // Channel 0 select, common select in rw mode
   input wire logic chan1_select_n, // Channel 1 select
   input wire logic chan2_select_n, // Channel 2 select
   input wire logic chan3_select_n, // Channel 3 select
   input wire logic read_strobe_n, // Read strobe, strobe mode only
   input wire logic write_strobe_n, // Write strobe, or read-not-write line
   input wire logic chan_addr_lo, // Channel address low, rw mode
   input wire logic chan_addr_hi, // Channel address high, rw mode
   input wire qhbs_addr_t reg_addr, // Register address
   input wire qhbs_byte_t data_in, // Data bus input
   output qhbs_byte_t data_out, // Data bus output, registered
   output logic data_oe, // Data bus drive enable
   output logic chip_rst, // Qualified chip reset
   output qhbs_byte_t [3:0] tx_data, // Transmit FIFO heads
   output logic [3:0] tx_valid, // Transmit FIFO not empty
   input wire logic [3:0] tx_take, // Serializer takes head byte
   input wire qhbs_byte_t [3:0] rx_data, // Received bytes
   input wire logic [3:0] rx_push, // Received byte strobes
   input wire logic [3:0] ser_tx_bit, // Serializer bits
   output logic [3:0] ser_tx_out, // Serial transmit pins
   output logic [3:0] irq_out, // Interrupt levels
   output logic [3:0] irq_oe // Interrupt drive enables
);
   qhbs_mode_t mode_q;
   qhbs_bus_st_t state_q, state_d;
   qhbs_sel_t sel_now, cs_active;
   qhbs_byte_t rd_mux;
   qhbs_byte_t ch_rd [4];
   qhbs_chan_req_t req_v [4];
   logic strobe_mode, rst_any, rd_now, wr_now, one_sel, wr_ev, rd_ev;

   // Bus style taken from the pin each cycle; an open or unknown pin gives read/write-line mode
   always_ff @(posedge clk)
   begin
      if (rst)
         mode_q <= QHBS_MODE_STROBE;
      else if (bus_style_sel)
         mode_q <= QHBS_MODE_STROBE;
      else
         mode_q <= QHBS_MODE_RWLINE;
   end

   assign strobe_mode = mode_q == QHBS_MODE_STROBE;

   // Reset pin qualification
   qhbs_rst_qual u_rst_qual (
      .clk(clk),
      .rst(rst),
      .reset_pin(chip_reset_pin),
      .strobe_mode(strobe_mode),
      .chip_rst(chip_rst)
   );

   // One reset for every channel at once
   assign rst_any = rst || chip_rst;

   assign cs_active = ~{chan3_select_n, chan2_select_n, chan1_select_n, chan0_select_n};

   // Channel and direction decode per bus style
   always_comb
   begin
      sel_now = `QHBS_SEL_NONE;
      rd_now = 1'b0;
      wr_now = 1'b0;
      if (strobe_mode)
      begin
         sel_now = cs_active;
         wr_now = !write_strobe_n;
         rd_now = !read_strobe_n && write_strobe_n;
      end
      else if (!chan0_select_n)
      begin
         sel_now = qhbs_sel_t'(1) << {chan_addr_hi, chan_addr_lo};
         wr_now = !write_strobe_n;
         rd_now = write_strobe_n;
      end
      if (sel_now == `QHBS_SEL_NONE)
      begin
         rd_now = 1'b0;
         wr_now = 1'b0;
      end
   end

   assign one_sel = $onehot(sel_now);

   // Bus cycle framing: one event per assertion of select and strobe
   always_comb
   begin
      state_d = state_q;
      wr_ev = 1'b0;
      rd_ev = 1'b0;
      case (state_q)
         QHBS_BUS_IDLE:
         begin
            if (wr_now)
            begin
               wr_ev = 1'b1;
               state_d = QHBS_BUS_WRITE;
            end
            else if (rd_now && one_sel)
            begin
               rd_ev = 1'b1;
               state_d = QHBS_BUS_READ;
            end
         end
         QHBS_BUS_WRITE:
         begin
            if (!wr_now)
               state_d = QHBS_BUS_IDLE;
         end
         QHBS_BUS_READ:
         begin
            if (!rd_now || !one_sel)
               state_d = QHBS_BUS_IDLE;
         end
         default:
         begin
            state_d = QHBS_BUS_IDLE;
         end
      endcase
      // No new access starts while any reset is applied
      if (rst_any)
      begin
         wr_ev = 1'b0;
         rd_ev = 1'b0;
      end
   end

   // Bus state register
   always_ff @(posedge clk)
   begin
      if (rst_any)
         state_q <= QHBS_BUS_IDLE;
      else
         state_q <= state_d;
   end

   // Per-channel access events and channel instances
   genvar ch;
   generate
      for (ch = 0; ch < `QHBS_NUM_CHAN; ch++)
      begin : g_chan
         assign req_v[ch].wr = wr_ev && sel_now[ch];
         assign req_v[ch].rd = rd_ev && sel_now[ch];
         assign req_v[ch].addr = reg_addr;
         assign req_v[ch].wdata = data_in;
         qhbs_chan u_chan (
            .clk(clk),
            .rst_any(rst_any),
            .req(req_v[ch]),
            .strobe_mode(strobe_mode),
            .irq_style_select(irq_style_select),
            .rd_data(ch_rd[ch]),
            .tx_data(tx_data[ch]),
            .tx_valid(tx_valid[ch]),
            .tx_take(tx_take[ch]),
            .rx_data(rx_data[ch]),
            .rx_push(rx_push[ch]),
            .ser_tx_bit(ser_tx_bit[ch]),
            .ser_tx_out(ser_tx_out[ch]),
            .irq({irq_out[ch], irq_oe[ch]})
         );
      end
   endgenerate

   // Read data from the one selected channel
   always_comb
   begin
      rd_mux = `QHBS_BYTE_ZERO;
      for (int i = 0; i < `QHBS_NUM_CHAN; i++)
      begin
         if (sel_now[i])
            rd_mux = ch_rd[i];
      end
   end

   // Read data captured at the start of the read cycle
   always_ff @(posedge clk)
   begin
      if (rst_any)
         data_out <= `QHBS_BYTE_ZERO;
      else if (rd_ev)
         data_out <= rd_mux;
   end

   // Drive only while a single-channel read is under way
   assign data_oe = state_q == QHBS_BUS_READ && rd_now && one_sel;

   // Checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence s_pin_high8;
      (strobe_mode && chip_reset_pin && $stable(mode_q)) [*8];
   endsequence

   sequence s_pin_low8;
      (!strobe_mode && !chip_reset_pin && $stable(mode_q)) [*8];
   endsequence

   sequence s_read_start;
      rd_ev ##1 (rd_now && one_sel);
   endsequence

   sequence s_write_cycle;
      wr_ev ##1 wr_now;
   endsequence

   AST_RST_HIGH_PULSE: assert property (s_pin_high8 |=> chip_rst)
      else $error("chip reset missing after 40 ns high pulse");

   AST_RST_LOW_PULSE: assert property (s_pin_low8 |=> chip_rst)
      else $error("chip reset missing after 40 ns low pulse");

   AST_RST_SHORT: assert property (
      (!chip_rst && strobe_mode && !chip_reset_pin) ##1
      (chip_reset_pin && strobe_mode) [*7] ##1 !chip_reset_pin |=> !chip_rst)
      else $error("short reset pulse accepted");

   AST_RST_TX_HIGH: assert property (chip_rst |=> ser_tx_out == `QHBS_SEL_ALL)
      else $error("transmit pin not held high in reset");

   AST_RST_ALL_CHAN: assert property (chip_rst |=> tx_valid == `QHBS_SEL_NONE && !data_oe)
      else $error("channel not cleared by reset");

   AST_READ_DATA: assert property (s_read_start |-> data_oe && data_out == $past(rd_mux))
      else $error("read data not presented from selected channel");

   AST_WRITE_ONCE: assert property (wr_ev |=> !wr_ev)
      else $error("write event repeated within one bus cycle");

   AST_NEW_CYCLE: assert property (
      (state_q == QHBS_BUS_WRITE && wr_now) |-> !wr_ev && !rd_ev)
      else $error("event without fresh strobe edge");

   AST_ONE_RESPONDER: assert property (rd_ev |-> $onehot(sel_now))
      else $error("read event with several channels");

   AST_STROBE_NONE: assert property (
      (strobe_mode && cs_active == `QHBS_SEL_NONE) |-> sel_now == `QHBS_SEL_NONE)
      else $error("channel selected with all selects high");

   AST_BROADCAST: assert property (
      (wr_ev && strobe_mode && cs_active == `QHBS_SEL_ALL) |->
      req_v[0].wr && req_v[1].wr && req_v[2].wr && req_v[3].wr)
      else $error("broadcast write missed a channel");

   AST_RW_DECODE: assert property (
      (!strobe_mode && !chan0_select_n) |->
      sel_now == qhbs_sel_t'(1) << {chan_addr_hi, chan_addr_lo})
      else $error("channel address decode wrong");

   AST_ADDR_IGNORED: assert property (
      (strobe_mode && $stable(cs_active) && $stable(mode_q)) |-> $stable(sel_now))
      else $error("channel address lines affected strobe mode");

   AST_MODE_PIN: assert property (
      bus_style_sel |=> strobe_mode ##0 (bus_style_sel [*1] or !bus_style_sel))
      else $error("bus style high did not give strobe mode");

   AST_MODE_LOW: assert property (!bus_style_sel |=> !strobe_mode)
      else $error("bus style low did not give read/write-line mode");

   AST_NO_DRIVE: assert property (
      data_oe |-> rd_now && $onehot(sel_now) && $past(rd_now))
      else $error("data bus driven outside a single read");

   // Chip reset releases as soon as the pin goes inactive
   AST_RST_REL_HIGH: assert property (
      (chip_rst && strobe_mode && !chip_reset_pin) |=> !chip_rst)
      else $error("chip reset held after high pin released");

   AST_RST_REL_LOW: assert property (
      (chip_rst && !strobe_mode && chip_reset_pin) |=> !chip_rst)
      else $error("chip reset held after low pin released");

   // Interrupt level, read data and bus events are cleared while the chip reset stands
   AST_RST_RX_IGNORED: assert property (chip_rst |=> irq_out == `QHBS_SEL_NONE)
      else $error("receive level survived reset");

   AST_RST_DATA_ZERO: assert property (chip_rst |=> data_out == `QHBS_BYTE_ZERO)
      else $error("read data not cleared by reset");

   AST_RST_NO_EVENT: assert property (chip_rst |-> !wr_ev && !rd_ev)
      else $error("bus access taken during reset");

   // Direction decode of each bus style
   AST_STROBE_DIR: assert property (strobe_mode |->
      wr_now == (!write_strobe_n && cs_active != `QHBS_SEL_NONE) &&
      rd_now == (!read_strobe_n && write_strobe_n && cs_active != `QHBS_SEL_NONE))
      else $error("strobe style direction decode wrong");

   AST_RW_DIR: assert property ((!strobe_mode && !chan0_select_n) |->
      wr_now == !write_strobe_n && rd_now == write_strobe_n)
      else $error("read/write-line direction decode wrong");

   AST_RW_NONE: assert property ((!strobe_mode && chan0_select_n) |->
      sel_now == `QHBS_SEL_NONE && !wr_now && !rd_now)
      else $error("channel selected with common select high");

   // A read to several channels is never answered
   AST_MULTI_READ: assert property ((rd_now && !one_sel) |-> !rd_ev && !data_oe)
      else $error("read answered with several channels selected");

   AST_IRQ_CONT: assert property ((!strobe_mode || irq_style_select) |->
      irq_oe == `QHBS_SEL_ALL)
      else $error("continuous interrupt output not enabled");

   AST_WRITE_HELD: assert property (s_write_cycle |->
      state_q == QHBS_BUS_WRITE && !wr_ev)
      else $error("held write strobe not tracked as one cycle");
endmodule : qhbs_host_port

// ### hdl/qhbs_map.svh
// Constants for the quad serial host bus select block
`ifndef QHBS_MAP_SVH
`define QHBS_MAP_SVH
`define QHBS_CLK_PERIOD_NS 5
`define QHBS_RST_MIN_NS 40
`define QHBS_RST_MIN_CYC ((`QHBS_RST_MIN_NS + `QHBS_CLK_PERIOD_NS - 1) / `QHBS_CLK_PERIOD_NS)
`define QHBS_RST_CNT_W 4
`define QHBS_NUM_CHAN 4
`define QHBS_DATA_W 8
`define QHBS_REG_AW 3
`define QHBS_REG_DATA 3'h0
`define QHBS_REG_MCR 3'h4
`define QHBS_MCR_IRQ_EN_BIT 3
`define QHBS_FIFO_DEPTH 16
`define QHBS_FIFO_AW 4
`define QHBS_BYTE_ZERO 8'h00
`define QHBS_TX_IDLE 1'b1
`define QHBS_SEL_NONE 4'h0
`define QHBS_SEL_ALL 4'hF
`endif

// ### hdl/qhbs_pkg.sv
// Types shared by the quad serial host bus select block
package qhbs_pkg;
`include "qhbs_map.svh"
   typedef enum logic {QHBS_MODE_RWLINE, QHBS_MODE_STROBE} qhbs_mode_t;
   typedef enum logic [1:0] {QHBS_BUS_IDLE, QHBS_BUS_WRITE, QHBS_BUS_READ} qhbs_bus_st_t;
   typedef logic [`QHBS_DATA_W-1:0] qhbs_byte_t;
   typedef logic [`QHBS_REG_AW-1:0] qhbs_addr_t;
   typedef logic [`QHBS_NUM_CHAN-1:0] qhbs_sel_t;
   typedef logic [`QHBS_FIFO_AW-1:0] qhbs_ptr_t;
   typedef logic [`QHBS_FIFO_AW:0] qhbs_cnt_t;
   typedef logic [`QHBS_RST_CNT_W-1:0] qhbs_rcnt_t;
   typedef struct packed {
      logic wr;
      logic rd;
      qhbs_addr_t addr;
      qhbs_byte_t wdata;
   } qhbs_chan_req_t;
   typedef struct packed {
      logic irq;
      logic oe;
   } qhbs_irq_t;
endpackage : qhbs_pkg

// ### hdl/qhbs_rst_qual.sv
// Chip reset pin qualifier with bus-style polarity and least pulse width
`timescale 1ns/100ps
`include "qhbs_map.svh"
module qhbs_rst_qual import qhbs_pkg::*; (
   input wire logic clk, // System clock
   input wire logic rst, // System reset, active high
   input wire logic reset_pin, // Chip reset pin, polarity set by bus style
   input wire logic strobe_mode, // High in strobe-style mode
   output logic chip_rst // Qualified chip reset
);
   localparam qhbs_rcnt_t MIN_M1 = qhbs_rcnt_t'(`QHBS_RST_MIN_CYC - 1);
   logic active;

   // Polarity follows the bus style
   assign active = strobe_mode ? reset_pin : ~reset_pin;

   // Count cycles the pin has been active
   qhbs_rcnt_t cnt_q;
   always_ff @(posedge clk)
   begin
      if (rst || !active)
         cnt_q <= '0;
      else if (cnt_q != MIN_M1)
         cnt_q <= cnt_q + qhbs_rcnt_t'(1);
   end

   // Reset holds until the pin goes inactive
   always_ff @(posedge clk)
   begin
      if (rst)
         chip_rst <= 1'b1;
      else
         chip_rst <= active && (chip_rst || cnt_q == MIN_M1);
   end
endmodule : qhbs_rst_qual

// ### hdl/qhbs_chan.sv
// One serial channel: register set, transmit and receive FIFOs
`timescale 1ns/100ps
`include "qhbs_map.svh"
module qhbs_chan import qhbs_pkg::*; (
   input wire logic clk, // System clock
   input wire logic rst_any, // System or chip reset
   input wire qhbs_chan_req_t req, // One-cycle access event
   input wire logic strobe_mode, // High in strobe-style mode
   input wire logic irq_style_select, // Interrupt style pin
   output qhbs_byte_t rd_data, // Read value for the addressed register
   output qhbs_byte_t tx_data, // Transmit FIFO head
   output logic tx_valid, // Transmit FIFO not empty
   input wire logic tx_take, // Serializer takes head byte
   input wire qhbs_byte_t rx_data, // Received byte
   input wire logic rx_push, // Received byte strobe
   input wire logic ser_tx_bit, // Serializer bit
   output logic ser_tx_out, // Serial transmit pin
   output qhbs_irq_t irq // Interrupt level and enable
);
   qhbs_byte_t regs_q [1:7];
   qhbs_byte_t tx_mem [`QHBS_FIFO_DEPTH];
   qhbs_byte_t rx_mem [`QHBS_FIFO_DEPTH];
   qhbs_ptr_t tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
   qhbs_cnt_t tx_cnt_q, rx_cnt_q;
   logic is_data, tx_push, tx_pop, rx_in, rx_pop;

   assign is_data = req.addr == `QHBS_REG_DATA;
   assign tx_push = req.wr && is_data && tx_cnt_q != qhbs_cnt_t'(`QHBS_FIFO_DEPTH);
   assign tx_pop = tx_take && tx_cnt_q != '0;
   assign rx_in = rx_push && !rst_any && rx_cnt_q != qhbs_cnt_t'(`QHBS_FIFO_DEPTH);
   assign rx_pop = req.rd && is_data && rx_cnt_q != '0;

   // FIFO storage, 16 bytes each way
   always_ff @(posedge clk)
   begin
      if (tx_push)
         tx_mem[tx_wp_q] <= req.wdata;
      if (rx_in)
         rx_mem[rx_wp_q] <= rx_data;
   end

   // FIFO pointers and counts
   always_ff @(posedge clk)
   begin
      if (rst_any)
      begin
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         tx_cnt_q <= '0;
         rx_cnt_q <= '0;
      end
      else
      begin
         tx_wp_q <= tx_wp_q + qhbs_ptr_t'(tx_push);
         tx_rp_q <= tx_rp_q + qhbs_ptr_t'(tx_pop);
         rx_wp_q <= rx_wp_q + qhbs_ptr_t'(rx_in);
         rx_rp_q <= rx_rp_q + qhbs_ptr_t'(rx_pop);
         tx_cnt_q <= tx_cnt_q + qhbs_cnt_t'(tx_push) - qhbs_cnt_t'(tx_pop);
         rx_cnt_q <= rx_cnt_q + qhbs_cnt_t'(rx_in) - qhbs_cnt_t'(rx_pop);
      end
   end

   // Configuration registers of this channel alone
   always_ff @(posedge clk)
   begin
      if (rst_any)
         regs_q <= '{default: `QHBS_BYTE_ZERO};
      else if (req.wr && !is_data)
         regs_q[req.addr] <= req.wdata;
   end

   // Serial transmit pin idles high in reset
   always_ff @(posedge clk)
   begin
      if (rst_any)
         ser_tx_out <= `QHBS_TX_IDLE;
      else
         ser_tx_out <= ser_tx_bit;
   end

   assign rd_data = is_data ? rx_mem[rx_rp_q] : regs_q[req.addr];
   assign tx_data = tx_mem[tx_rp_q];
   assign tx_valid = tx_cnt_q != '0;
   assign irq.irq = rx_cnt_q != '0;
   // Software-gated output only in strobe mode with style pin low
   assign irq.oe = (strobe_mode && !irq_style_select) ?
                   regs_q[`QHBS_REG_MCR][`QHBS_MCR_IRQ_EN_BIT] : 1'b1;
endmodule : qhbs_chan

// ### bench/qhbs_host_model.sv
// Host processor model that drives the shared bus of the quad serial port
`timescale 1ns/100ps
module qhbs_host_model import qhbs_pkg::*; (
   input wire logic clk, // System clock
   input wire logic strobe_mode, // High in strobe-style mode
   output logic [3:0] sel_n, // Channel selects, bit 0 is the common select in rw mode
   output logic rd_n, // Read strobe
   output logic wr_n, // Write strobe or read-not-write line
   output logic a_lo, // Channel address low
   output logic a_hi, // Channel address high
   output qhbs_addr_t addr, // Register address
   output qhbs_byte_t dout, // Host data, inverted once released
   output logic rd_one // High while a read to one channel is held
);
   int seed = 61317;

   // Idle bus at time zero
   initial
   begin
      sel_n = 4'hF;
      rd_n = 1'b1;
      wr_n = 1'b1;
      a_lo = 1'b0;
      a_hi = 1'b0;
      addr = 3'h0;
      dout = 8'h00;
      rd_one = 1'b0;
   end

   // One access held for three edges, then one idle cycle with selects high
   task automatic access(input logic rd, input qhbs_sel_t sel, input logic [1:0] ch,
                         input qhbs_addr_t a, input qhbs_byte_t d);
      logic [31:0] r;
      r = $random(seed);
      @(posedge clk);
      if (strobe_mode)
      begin
         sel_n <= ~sel;
         rd_n <= ~rd;
         {a_hi, a_lo} <= r[1:0]; // Noise on lines that strobe mode ignores
         rd_one <= rd && $onehot(sel);
      end
      else
      begin
         sel_n <= {r[2:0], 1'b0};
         rd_n <= r[3];
         {a_hi, a_lo} <= ch;
         rd_one <= rd;
      end
      wr_n <= rd;
      addr <= a;
      if (!rd)
         dout <= d;
      repeat (3) @(posedge clk);
      sel_n <= 4'hF;
      rd_n <= 1'b1;
      wr_n <= 1'b1;
      rd_one <= 1'b0;
      if (!rd)
         dout <= ~d; // Released bus shows the inverse of the last value
   endtask : access
endmodule : qhbs_host_model

// ### bench/qhbs_host_port_tb.sv
// Self-checking testbench of the quad serial host bus front end
`timescale 1ns/100ps
module qhbs_host_port_tb import qhbs_pkg::*;;
   logic clk, rst = 1'b1, style = 1'b1, irqsel = 1'b0, crp = 1'b0;
   logic [3:0] sel_n;
   logic rd_n, wr_n, a_lo, a_hi, rd_one, data_oe, chip_rst, prev_oe = 1'b0;
   qhbs_addr_t addr;
   qhbs_byte_t hdout, data_in, data_out;
   qhbs_byte_t [3:0] tx_data, rx_data;
   logic [3:0] tx_valid, tx_take, rx_push, ser_tx_bit, ser_tx_out, irq_out, irq_oe;
   qhbs_byte_t exp_q[$];
   qhbs_byte_t v[4];
   int fails = 0, checks = 0, seed = 61317, hi_cnt = 0, base;

   // Device drives the bus only when enabled, otherwise the host side shows
   assign data_in = (data_oe === 1'b1) ? data_out : hdout;

   qhbs_host_model qhbs_host_model_i (.clk(clk), .strobe_mode(style), .sel_n(sel_n),
      .rd_n(rd_n), .wr_n(wr_n), .a_lo(a_lo), .a_hi(a_hi), .addr(addr), .dout(hdout),
      .rd_one(rd_one));

   qhbs_host_port qhbs_host_port_i (.clk(clk), .rst(rst), .bus_style_sel(style),
      .irq_style_select(irqsel), .chip_reset_pin(crp), .chan0_select_n(sel_n[0]),
      .chan1_select_n(sel_n[1]), .chan2_select_n(sel_n[2]), .chan3_select_n(sel_n[3]),
      .read_strobe_n(rd_n), .write_strobe_n(wr_n), .chan_addr_lo(a_lo),
      .chan_addr_hi(a_hi), .reg_addr(addr), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .chip_rst(chip_rst), .tx_data(tx_data), .tx_valid(tx_valid),
      .tx_take(tx_take), .rx_data(rx_data), .rx_push(rx_push), .ser_tx_bit(ser_tx_bit),
      .ser_tx_out(ser_tx_out), .irq_out(irq_out), .irq_oe(irq_oe));

   // 200 MHz clock
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask : tick

   task automatic chk(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("BAD %0t %s", $time, what);
      end
   endtask : chk

   task automatic wr(input qhbs_sel_t s, input logic [1:0] c, input qhbs_addr_t a,
                     input qhbs_byte_t d);
      qhbs_host_model_i.access(1'b0, s, c, a, d);
   endtask : wr

   // Note the expected byte, then run the read
   task automatic rd(input qhbs_sel_t s, input logic [1:0] c, input qhbs_addr_t a,
                     input qhbs_byte_t e);
      exp_q.push_back(e);
      qhbs_host_model_i.access(1'b1, s, c, a, e);
   endtask : rd

   task automatic stop_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : stop_test

   // Compares each read answer with the oldest note; counts chip reset cycles
   always @(posedge clk)
   begin
      prev_oe <= data_oe;
      if (chip_rst === 1'b1)
         hi_cnt <= hi_cnt + 1;
      if (data_oe === 1'b1 && prev_oe !== 1'b1)
      begin
         checks++;
         if (exp_q.size() == 0 || data_out !== exp_q[0])
         begin
            fails++;
            $display("BAD %0t read data %h", $time, data_out);
         end
         if (exp_q.size() != 0)
            void'(exp_q.pop_front());
      end
      if (data_oe === 1'b1 && rd_one !== 1'b1)
      begin
         fails++;
         $display("BAD %0t bus driven outside a single read", $time);
      end
   end

   // Watchdog
   initial
   begin
      tick(20000);
      fails++;
      $display("BAD %0t timeout", $time);
      stop_test;
   end

   // Main sequence
   initial
   begin
      tx_take = 4'h0;
      rx_data = '0;
      rx_push = 4'h0;
      ser_tx_bit = 4'h0;
      tick(12);
      chk(ser_tx_out === 4'hF && tx_valid === 4'h0 && data_oe === 1'b0, "reset");
      rst <= 1'b0;
      tick(4);
      chk(ser_tx_out === 4'h0 && chip_rst === 1'b0, "released");
      // Each channel keeps its own register
      for (int c = 0; c < 4; c++)
      begin
         v[c] = 8'($random(seed));
         wr(qhbs_sel_t'(4'h1 << c), 2'h0, 3'h7, v[c]);
      end
      for (int c = 0; c < 4; c++)
         rd(qhbs_sel_t'(4'h1 << c), 2'(3 - c), 3'h7, v[c]);
      // Broadcast write, then reads with none and with two selected
      v[0] = 8'($random(seed));
      wr(4'hF, 2'h0, 3'h3, v[0]);
      for (int c = 0; c < 4; c++)
         rd(qhbs_sel_t'(4'h1 << c), 2'h0, 3'h3, v[0]);
      qhbs_host_model_i.access(1'b1, 4'h0, 2'h0, 3'h3, 8'h00);
      qhbs_host_model_i.access(1'b1, 4'h3, 2'h0, 3'h3, 8'h00);
      // Transmit FIFO takes sixteen bytes and drops the seventeenth
      for (int i = 0; i < 17; i++)
         wr(4'h1, 2'h0, 3'h0, 8'(i));
      for (int i = 0; i < 16; i++)
      begin
         tick(1);
         chk(tx_valid[0] === 1'b1 && tx_data[0] === 8'(i), "tx head");
         tx_take[0] <= 1'b1;
         tick(1);
         tx_take[0] <= 1'b0;
      end
      tick(1);
      chk(tx_valid[0] === 1'b0, "tx drop");
      // Receive byte raises the level and is read back
      v[1] = 8'($random(seed));
      rx_data[1] <= v[1];
      rx_push[1] <= 1'b1;
      tick(1);
      rx_push[1] <= 1'b0;
      tick(3);
      chk(irq_out === 4'h2, "rx level");
      rd(4'h2, 2'h0, 3'h0, v[1]);
      tick(3);
      chk(irq_out === 4'h0, "rx empty");
      // Interrupt enable by style pin and control bit 3
      irqsel <= 1'b1;
      tick(3);
      chk(irq_oe === 4'hF, "continuous irq");
      irqsel <= 1'b0;
      wr(4'h4, 2'h0, 3'h4, 8'h08);
      tick(3);
      chk(irq_oe === 4'h4, "gated irq");
      // Chip reset pin in strobe mode: short pulse ignored, long pulse clears all
      base = hi_cnt;
      crp <= 1'b1;
      tick(7);
      crp <= 1'b0;
      tick(3);
      chk(hi_cnt === base, "short reset");
      wr(4'h1, 2'h0, 3'h0, 8'h5A);
      crp <= 1'b1;
      tick(10);
      chk(chip_rst === 1'b1 && ser_tx_out === 4'hF && data_oe === 1'b0, "held");
      rx_push[0] <= 1'b1; // Byte arriving in reset is dropped
      tick(1);
      rx_push[0] <= 1'b0;
      crp <= 1'b0;
      tick(4);
      chk(chip_rst === 1'b0 && tx_valid === 4'h0 && irq_oe === 4'h0, "reset all");
      chk(irq_out === 4'h0, "rx in reset");
      // Read/write-line mode with channel address lines
      style <= 1'b0;
      crp <= 1'b1;
      tick(4);
      for (int c = 0; c < 4; c++)
      begin
         v[c] = 8'($random(seed));
         wr(4'h0, 2'(c), 3'h5, v[c]);
      end
      for (int c = 0; c < 4; c++)
         rd(4'h0, 2'(c), 3'h5, v[c]);
      // Active low chip reset in read/write-line mode
      crp <= 1'b0;
      tick(10);
      chk(chip_rst === 1'b1, "low reset");
      crp <= 1'b1;
      tick(4);
      rd(4'h0, 2'h2, 3'h5, 8'h00);
      // Style pin high returns to strobe mode
      style <= 1'b1;
      crp <= 1'b0;
      tick(4);
      rd(4'h8, 2'h0, 3'h5, 8'h00);
      tick(6);
      chk(exp_q.size() == 0, "reads answered");
      stop_test;
   end
endmodule : qhbs_host_port_tb
